/* hdl/msf_limit_cmp.sv */
// Purpose: Window comparison of one reading against its low and high limit
// Assumes: Signed channels hold twos complement readings
// Notes:   Combinational; the caller registers the result into a flag
`timescale 1ns/10ps
module msf_limit_cmp (
  input  wire logic [7:0] i_reading,
  input  wire logic [7:0] i_lo,
  input  wire logic [7:0] i_hi,
  input  wire logic       i_signed,
  output logic            o_out
);
  logic [7:0] flip;
  logic [7:0] rd_b;
  logic [7:0] lo_b;
  logic [7:0] hi_b;

  // Flipping the sign bit turns a signed order into an unsigned one
  assign flip = {i_signed, 7'h00};
  assign rd_b = i_reading ^ flip;
  assign lo_b = i_lo ^ flip;
  assign hi_b = i_hi ^ flip;
  assign o_out = (rd_b > hi_b) | (rd_b <= lo_b);

endmodule : msf_limit_cmp

/* hdl/msf_pkg.sv */
// Purpose: Shared constants and types for the monitor status flag block
// Assumes: Register indices are word indices; byte address is index * 4
// Notes:   One timer tick per TMR_TICK_NS of overheat pin assertion
package msf_pkg;

  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_LIM = 5;
  localparam int unsigned NUM_FAN = 4;

  // Register indices
  localparam logic [7:0] REG_CFG1     = 8'h40;
  localparam logic [7:0] REG_ST1      = 8'h41;
  localparam logic [7:0] REG_ST2      = 8'h42;
  localparam logic [7:0] REG_VLIM     = 8'h46;
  localparam logic [7:0] REG_TLIM     = 8'h4E;
  localparam logic [7:0] REG_FAN_SPEED_INPUT_MIN = 8'h54;
  localparam logic [7:0] REG_TMR_LIM  = 8'h7A;
  localparam logic [7:0] REG_IRQ_ST   = 8'h80;
  localparam logic [7:0] REG_IRQ_MASK = 8'h81;
  localparam logic [7:0] REG_PIN_MODE = 8'h82;

  // Field positions
  localparam int unsigned ST1_PROC    = 1;
  localparam int unsigned ST1_VCC     = 2;
  localparam int unsigned ST1_REM_ONE = 4;
  localparam int unsigned ST1_SUMMARY = 7;
  localparam int unsigned ST2_HEAT    = 1;
  localparam int unsigned ST2_FAN_ONE = 2;
  localparam int unsigned ST2_SHARED  = 5;
  localparam int unsigned ST2_DIODE1  = 6;
  localparam int unsigned CFG_START   = 0;
  localparam int unsigned CFG_LOCK    = 1;
  localparam int unsigned CFG_FULL    = 3;

  localparam logic [7:0] ST1_USED_MASK    = 8'h76;
  localparam logic [7:0] ST2_USED_MASK    = 8'hFE;
  localparam logic [7:0] IRQ_USED_MASK    = 8'hF6;
  localparam logic [7:0] CFG1_WR_MASK     = 8'h7B;
  localparam logic [7:0] CFG1_LOCKED_MASK = 8'h29;

  // Reset values, and the zero fan minimum that marks an unused input
  localparam logic [7:0]  ST_RST       = 8'h00;
  localparam logic [7:0]  CFG1_RST     = 8'h04;
  localparam logic [7:0]  VLIM_LO_RST  = 8'h00;
  localparam logic [7:0]  VLIM_HI_RST  = 8'hFF;
  localparam logic [7:0]  TLIM_LO_RST  = 8'h81;
  localparam logic [7:0]  TLIM_HI_RST  = 8'h7F;
  localparam logic [15:0] FAN_SPEED_INPUT_MIN_RST = 16'hFFFF;
  localparam logic [15:0] FAN_SPEED_INPUT_MIN_OFF = 16'h0000;
  localparam logic [7:0]  TMR_LIM_RST  = 8'hFF;
  localparam logic [7:0]  MASK_RST     = 8'h00;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TMR_TICK_NS   = 1000;
  localparam int unsigned TMR_TICK_CYC  = TMR_TICK_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    msf_pin_fan_speed_input,
    msf_pin_gpio,
    msf_pin_timer
  } msf_pin_mode_t;

  // Field order puts the processor supply at index 0 of the packed view
  typedef struct packed {
    logic [7:0] temp_r2;
    logic [7:0] temp_local;
    logic [7:0] temp_r1;
    logic [7:0] vcc;
    logic [7:0] proc_sup;
  } msf_readings_t;

  typedef struct packed {
    logic [NUM_FAN-1:0][15:0] count;
    logic [2:0]               drive_on;
  } msf_fan_t;

  function automatic logic [7:0] msf_lim_idx(input int unsigned ch);
    return (ch < 2) ? REG_VLIM + 8'(2 * ch) : REG_TLIM + 8'(2 * (ch - 2));
  endfunction : msf_lim_idx

  function automatic logic [7:0] msf_fan_speed_input_idx(input int unsigned f);
    return REG_FAN_SPEED_INPUT_MIN + 8'(2 * f);
  endfunction : msf_fan_speed_input_idx

endpackage : msf_pkg

/* hdl/msf_status.sv */
// Purpose: Sticky out-of-limit status flags behind an Avalon-MM slave
// Assumes: Readings, fan counts and fault levels are synchronous inputs
// Notes:   Every access takes one wait cycle; read data is sampled early
`timescale 1ns/10ps

// Functional notes
// - Supply limit crossings set primary bits 1, 2
// - Temperature limit crossings set primary bits 4-6
// - Read clears primary flag only if cleared
// - Primary bit 7 is OR of secondary
// - Both status registers zero after reset
// - Overheat limit exceeded sets secondary bit 1
// - Overheat flag clears only below hysteresis point
// - Slow or stalled fans one-three set bits 2-4
// - Fan flags suppressed while their drive off
// - Shared pin as fan four sets bit 5
// - Shared pin as output: bit 5 writable
// - Timer mode: long assertion sets bit 5
// - Diode open or short sets bits 6, 7
// - Start bit stays writable after lock
// - Monitoring off forces fans to full drive
// - High limit strict, low limit inclusive
// - Period count above minimum flags slow fan
module msf_status #(
  parameter int unsigned TICK_CYC = msf_pkg::TMR_TICK_CYC
) (
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rstn,
  input  wire logic [msf_pkg::ADDR_W-1:0]    i_avs_address,
  input  wire logic                          i_avs_read,
  input  wire logic                          i_avs_write,
  input  wire logic [msf_pkg::DATA_W-1:0]    i_avs_writedata,
  input  wire logic [3:0]                    i_avs_byteenable,
  output logic      [msf_pkg::DATA_W-1:0]    o_avs_readdata,
  output logic                               o_avs_waitrequest,
  input  wire msf_pkg::msf_readings_t        i_readings,
  input  wire msf_pkg::msf_fan_t             i_fan,
  input  wire logic                          i_overheat_exceed,
  input  wire logic                          i_overheat_cool,
  input  wire logic                          i_shared_pin_in_n,
  input  wire logic [1:0]                    i_diode_fault,
  output logic                               o_shared_pin_out,
  output logic                               o_shared_pin_oe,
  output logic                               o_monitor_en,
  output logic                               o_drive_full,
  output logic                               o_irq
);
  import msf_pkg::*;

  logic                wait_q;
  logic [DATA_W-1:0]   rdata_q;
  logic [7:0]          idx;
  logic                aligned;
  logic                req;
  logic                acc_rd;
  logic                wr_en;
  logic [7:0]          wdat;
  logic [7:0]          rd_mux;
  logic [7:0]          cfg_q;
  logic [7:0]          lim_lo_q [NUM_LIM];
  logic [7:0]          lim_hi_q [NUM_LIM];
  logic [15:0]         fan_speed_input_min_q [NUM_FAN];
  logic [7:0]          tmr_lim_q;
  logic [7:0]          mask_q;
  msf_pin_mode_t       pin_mode_q;
  logic                pin_oe_q;
  logic                drive_full_q;
  logic                irq_q;
  logic [7:0]          st1_q;
  logic [7:0]          st1_d;
  logic [7:0]          st2_q;
  logic [7:0]          st2_d;
  logic [7:0]          irq_st_q;
  logic [7:0]          irq_st_d;
  logic [7:0]          cond1;
  logic [7:0]          cond2;
  logic [7:0]          clr1;
  logic [7:0]          clr2;
  logic [7:0]          ev;
  logic [7:0]          st1_view;
  logic [NUM_LIM-1:0]  lim_out;
  logic [NUM_FAN-1:0]  fan_cond;
  logic [NUM_LIM-1:0][7:0] rd_arr;
  logic [7:0]          tick_cnt_q;
  logic                tick;
  logic [8:0]          ovt_cnt_q;
  logic                tmr_over;
  logic                shared_cond;
  logic                gpio_mode;

  assign idx     = i_avs_address[ADDR_W-1:2];
  assign aligned = (i_avs_address[1:0] == 2'b00);
  assign req     = i_avs_read | i_avs_write;
  assign acc_rd  = req & ~wait_q & i_avs_read & aligned;
  assign wr_en   = req & ~wait_q & i_avs_write & aligned & i_avs_byteenable[0];
  assign wdat    = i_avs_writedata[7:0];
  assign gpio_mode = (pin_mode_q == msf_pin_gpio);

  // One wait cycle lets read data settle into a flop before acceptance
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(req & wait_q);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_q <= 32'h0000_0000;
    end else if (req && wait_q && i_avs_read) begin
      rdata_q <= {24'h00_0000, rd_mux};
    end
  end

  assign o_avs_readdata    = rdata_q;
  assign o_avs_waitrequest = wait_q;

  assign st1_view = st1_q | {|st2_q, 7'h00};

  always_comb begin
    rd_mux = 8'h00;
    if (aligned) begin
      unique case (idx)
        REG_CFG1:     rd_mux = cfg_q;
        REG_ST1:      rd_mux = st1_view;
        REG_ST2:      rd_mux = st2_q;
        REG_TMR_LIM:  rd_mux = tmr_lim_q;
        REG_IRQ_ST:   rd_mux = irq_st_q;
        REG_IRQ_MASK: rd_mux = mask_q;
        REG_PIN_MODE: rd_mux = {6'h00, pin_mode_q};
        default:      rd_mux = 8'h00;
      endcase
      for (int c = 0; c < NUM_LIM; c++) begin
        if (idx == msf_lim_idx(c)) rd_mux = lim_lo_q[c];
        if (idx == msf_lim_idx(c) + 8'h01) rd_mux = lim_hi_q[c];
      end
      for (int f = 0; f < NUM_FAN; f++) begin
        if (idx == msf_fan_speed_input_idx(f)) rd_mux = fan_speed_input_min_q[f][7:0];
        if (idx == msf_fan_speed_input_idx(f) + 8'h01) rd_mux = fan_speed_input_min_q[f][15:8];
      end
    end
  end

  // Lock is write once; start, full speed and spin-up stay writable
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_q <= CFG1_RST;
    end else if (wr_en && idx == REG_CFG1) begin
      if (cfg_q[CFG_LOCK]) begin
        cfg_q <= (cfg_q & ~CFG1_LOCKED_MASK) | (wdat & CFG1_LOCKED_MASK);
      end else begin
        cfg_q <= (cfg_q & ~CFG1_WR_MASK) | (wdat & CFG1_WR_MASK);
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tmr_lim_q  <= TMR_LIM_RST;
      mask_q     <= MASK_RST;
      pin_mode_q <= msf_pin_fan_speed_input;
    end else if (wr_en) begin
      if (idx == REG_TMR_LIM) tmr_lim_q <= wdat;
      if (idx == REG_IRQ_MASK) mask_q <= wdat & IRQ_USED_MASK;
      if (idx == REG_PIN_MODE && wdat[1:0] != 2'b11) begin
        pin_mode_q <= msf_pin_mode_t'(wdat[1:0]);
      end
    end
  end

  assign rd_arr = i_readings;

  for (genvar g = 0; g < NUM_LIM; g++) begin : g_lim
    localparam logic [7:0] LO_A = msf_lim_idx(g);
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        lim_lo_q[g] <= (g < 2) ? VLIM_LO_RST : TLIM_LO_RST;
        lim_hi_q[g] <= (g < 2) ? VLIM_HI_RST : TLIM_HI_RST;
      end else if (wr_en && idx == LO_A) begin
        lim_lo_q[g] <= wdat;
      end else if (wr_en && idx == LO_A + 8'h01) begin
        lim_hi_q[g] <= wdat;
      end
    end
    msf_limit_cmp u_cmp (
      .i_reading (rd_arr[g]),
      .i_lo      (lim_lo_q[g]),
      .i_hi      (lim_hi_q[g]),
      .i_signed  (g >= 2),
      .o_out     (lim_out[g])
    );
  end

  for (genvar f = 0; f < NUM_FAN; f++) begin : g_fan
    localparam logic [7:0] LO_A = msf_fan_speed_input_idx(f);
    localparam int unsigned DRV = (f < 3) ? f : 2;
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        fan_speed_input_min_q[f] <= FAN_SPEED_INPUT_MIN_RST;
      end else if (wr_en && idx == LO_A) begin
        fan_speed_input_min_q[f][7:0] <= wdat;
      end else if (wr_en && idx == LO_A + 8'h01) begin
        fan_speed_input_min_q[f][15:8] <= wdat;
      end
    end
    // All-ones or zero minimum marks an unused fan input
    assign fan_cond[f] = (i_fan.count[f] > fan_speed_input_min_q[f])
                       & (fan_speed_input_min_q[f] != FAN_SPEED_INPUT_MIN_RST)
                       & (fan_speed_input_min_q[f] != FAN_SPEED_INPUT_MIN_OFF)
                       & i_fan.drive_on[DRV];
  end

  // Overheat timer accumulates assertion ticks until status is read
  assign tick = (tick_cnt_q == 8'(TICK_CYC - 1));

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_cnt_q <= 8'h00;
    end else begin
      tick_cnt_q <= tick ? 8'h00 : tick_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ovt_cnt_q <= 9'h000;
    end else if (pin_mode_q != msf_pin_timer || (acc_rd && idx == REG_ST2)) begin
      ovt_cnt_q <= 9'h000;
    end else if (tick && !i_shared_pin_in_n && ovt_cnt_q != 9'h1FF) begin
      ovt_cnt_q <= ovt_cnt_q + 9'h001;
    end
  end

  assign tmr_over = ovt_cnt_q > {1'b0, tmr_lim_q};

  always_comb begin
    unique case (pin_mode_q)
      msf_pin_fan_speed_input:  shared_cond = fan_cond[3];
      msf_pin_timer: shared_cond = tmr_over;
      default:       shared_cond = 1'b0;
    endcase
  end

  assign cond1 = {1'b0, lim_out[4:2], 1'b0, lim_out[1:0], 1'b0};
  assign cond2 = {i_diode_fault, shared_cond, fan_cond[2:0],
                  i_overheat_exceed, 1'b0};

  // Only bits that the host actually saw are cleared by its read
  assign clr1 = (acc_rd && idx == REG_ST1) ? rdata_q[7:0] : 8'h00;
  always_comb begin
    clr2 = (acc_rd && idx == REG_ST2) ? rdata_q[7:0] : 8'h00;
    clr2[ST2_HEAT] = clr2[ST2_HEAT] & i_overheat_cool;
  end

  assign st1_d = (cond1 | (st1_q & ~clr1)) & ST1_USED_MASK;

  always_comb begin
    st2_d = (cond2 | (st2_q & ~clr2)) & ST2_USED_MASK;
    if (gpio_mode) begin
      st2_d[ST2_SHARED] = (wr_en && idx == REG_ST2) ? wdat[ST2_SHARED]
                                                   : st2_q[ST2_SHARED];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st1_q <= ST_RST;
      st2_q <= ST_RST;
    end else begin
      st1_q <= st1_d;
      st2_q <= st2_d;
    end
  end

  // Interrupt events: new primary flags, or any new secondary flag except bit 5 in GPIO mode
  always_comb begin
    ev = st1_d & ~st1_q;
    ev[ST1_SUMMARY] = |((st2_d & ~st2_q) & ~{2'b00, gpio_mode, 5'h00});
    irq_st_d = ev & IRQ_USED_MASK;
    irq_st_d = irq_st_d | (irq_st_q & ~((wr_en && idx == REG_IRQ_ST) ? wdat : 8'h00));
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_st_q <= ST_RST;
      irq_q    <= 1'b0;
    end else begin
      irq_st_q <= irq_st_d;
      irq_q    <= |(irq_st_q & mask_q);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      drive_full_q <= 1'b1;
      pin_oe_q     <= 1'b0;
    end else begin
      drive_full_q <= ~cfg_q[CFG_START] | cfg_q[CFG_FULL];
      pin_oe_q     <= gpio_mode;
    end
  end

  assign o_monitor_en     = cfg_q[CFG_START];
  assign o_drive_full     = drive_full_q;
  assign o_shared_pin_out = st2_q[ST2_SHARED];
  assign o_shared_pin_oe  = pin_oe_q;
  assign o_irq            = irq_q;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  chk_wait_release: assert property (
    req && wait_q |=> !wait_q ##1 wait_q)
    else $error("wait request not released for one cycle");

  chk_summary_or: assert property (
    req && wait_q && i_avs_read && aligned && idx == REG_ST1
    |=> rdata_q[ST1_SUMMARY] == |$past(st2_q))
    else $error("summary bit differs from secondary OR");

  chk_read_clears: assert property (
    acc_rd && idx == REG_ST1 && rdata_q[ST1_PROC] && !lim_out[0]
    |=> !st1_q[ST1_PROC])
    else $error("supply flag kept after clearing read");

  chk_active_kept: assert property (
    lim_out[2] |=> st1_q[ST1_REM_ONE] && st1_view[ST1_REM_ONE])
    else $error("active temperature condition lost");

  chk_ovt_hold: assert property (
    st2_q[ST2_HEAT] && !i_overheat_cool |=> st2_q[ST2_HEAT])
    else $error("overheat flag cleared above hysteresis");

  chk_fan_drive: assert property (
    $rose(st2_q[ST2_FAN_ONE]) |-> $past(i_fan.drive_on[0]))
    else $error("fan one flag set with drive off");

  chk_reserved_zero: assert property (
    st1_view[0] == 1'b0 && st1_view[3] == 1'b0 && st2_q[0] == 1'b0)
    else $error("reserved status bit set");

  chk_start_locked: assert property (
    wr_en && idx == REG_CFG1 && cfg_q[CFG_LOCK]
    |=> o_monitor_en == $past(wdat[CFG_START]) ##1 o_drive_full ==
        (~$past(wdat[CFG_START], 2) | cfg_q[CFG_FULL]))
    else $error("start bit not writable under lock");

  chk_gpio_write: assert property (
    wr_en && idx == REG_ST2 && gpio_mode
    |=> o_shared_pin_out == $past(wdat[ST2_SHARED]) && o_shared_pin_oe)
    else $error("gpio level not taken from write");

  chk_timer_flag: assert property (
    pin_mode_q == msf_pin_timer && tmr_over |=> st2_q[ST2_SHARED])
    else $error("timer overrun did not set shared flag");

  chk_irq_level: assert property (
    |(irq_st_q & mask_q) |=> o_irq)
    else $error("interrupt not raised for unmasked event");

  cov_clear_read: cover property (
    acc_rd && idx == REG_ST1 && |rdata_q[7:0] ##1 st1_q == 8'h00);
  cov_ovt_kept: cover property (
    acc_rd && idx == REG_ST2 && rdata_q[ST2_HEAT] && !i_overheat_cool);
  cov_irq: cover property ($rose(o_irq));
  cov_timer: cover property (pin_mode_q == msf_pin_timer && tmr_over);

endmodule : msf_status

/* tb/test_monitor_status_flags.sv */
// Purpose: Self-checking bench for the monitor status flag block
// Assumes: Flags settle within three cycles of a level change
// Notes:   Timer tick shortened to four cycles to keep the run short
`timescale 1ns/10ps
module test_monitor_status_flags;
  import msf_pkg::*;

  localparam logic [7:0] LO  = 8'h20;
  localparam logic [7:0] HI  = 8'h60;
  localparam logic [7:0] MID = 8'h40;

  logic              clk;
  logic              rstn;
  logic [ADDR_W-1:0] address;
  logic              read;
  logic              write;
  logic [DATA_W-1:0] writedata;
  logic [DATA_W-1:0] readdata;
  logic              waitreq;
  logic [4:0][7:0]   rdg;
  msf_fan_t          fan;
  logic              ovt_exceed;
  logic              ovt_cool;
  logic              pin_in_n;
  logic [1:0]        diode;
  logic              pin_out;
  logic              pin_oe;
  logic              mon_en;
  logic              drv_full;
  logic              irq;
  int                n_errors;
  int                n_tests;
  int                seed;
  int                ch;
  int                dsel;
  logic [7:0]        r;
  logic [7:0]        e;

  msf_status #(.TICK_CYC(4)) msf_status_inst (
    .i_core_clk        (clk),
    .i_rstn            (rstn),
    .i_avs_address     (address),
    .i_avs_read        (read),
    .i_avs_write       (write),
    .i_avs_writedata   (writedata),
    .i_avs_byteenable  (4'h1),
    .o_avs_readdata    (readdata),
    .o_avs_waitrequest (waitreq),
    .i_readings        (rdg),
    .i_fan             (fan),
    .i_overheat_exceed (ovt_exceed),
    .i_overheat_cool   (ovt_cool),
    .i_shared_pin_in_n (pin_in_n),
    .i_diode_fault     (diode),
    .o_shared_pin_out  (pin_out),
    .o_shared_pin_oe   (pin_oe),
    .o_monitor_en      (mon_en),
    .o_drive_full      (drv_full),
    .o_irq             (irq)
  );

  always #2.5 clk = ~clk;

  function automatic logic [7:0] lim_idx(input int c);
    return (c < 2) ? 8'h46 + 8'(2 * c) : 8'h4E + 8'(2 * (c - 2));
  endfunction : lim_idx

  function automatic logic [7:0] st1_bit(input int c);
    return (c < 2) ? 8'h01 << (c + 1) : 8'h01 << (c + 2);
  endfunction : st1_bit

  // Supplies compare unsigned, temperatures twos complement
  function automatic logic viol(input int c, input logic [7:0] v);
    if (c < 2) begin
      return (v > HI) || (v <= LO);
    end
    return ($signed(v) > $signed(HI)) || ($signed(v) <= $signed(LO));
  endfunction : viol

  task automatic results();
    if (n_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [9:0] adr,
                     input logic [7:0] wd, output logic [7:0] rd);
    int k;
    @(posedge clk);
    address   <= adr;
    read      <= ~wr;
    write     <= wr;
    writedata <= {24'h00_0000, wd};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (waitreq !== 1'b0 && k < 50);
    rd = readdata[7:0];
    if (waitreq !== 1'b0) begin
      n_errors++;
      $display("[FAIL] %0t bus access timed out", $time);
      results();
    end
    if (!wr) begin
      chk({7'h00, |readdata[31:8]}, 8'h00, "readdata upper bits");
    end
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] unused;
    bus(1'b1, {idx, 2'b00}, d, unused);
  endtask : wr

  task automatic rchk(input logic [9:0] adr, input logic [7:0] exp,
                      input string what);
    logic [7:0] d;
    bus(1'b0, adr, 8'h00, d);
    chk(d, exp, what);
  endtask : rchk

  // Flag latency is a few edges; sample on a falling edge
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    rdg = {5{MID}};
    fan = '0;
    ovt_exceed = 1'b0;
    ovt_cool = 1'b1;
    pin_in_n = 1'b1;
    diode = 2'b00;
    n_errors = 0;
    n_tests = 0;
    seed = 32'h3c5d7326;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk({7'h00, drv_full}, 8'h01, "full drive at reset");
    chk({6'h00, mon_en, irq}, 8'h00, "outputs at reset");
    rchk({REG_ST1, 2'b00}, 8'h00, "primary reset");
    rchk({REG_ST2, 2'b00}, 8'h00, "secondary reset");
    rchk({REG_CFG1, 2'b00}, 8'h04, "config reset");
    wr(REG_ST1, 8'hFF);
    wr(REG_ST2, 8'hFF);
    rchk({REG_ST1, 2'b00}, 8'h00, "primary read only");
    rchk({REG_ST2, 2'b00}, 8'h00, "secondary read only");
    rchk(10'h3FC, 8'h00, "unmapped read");
    rchk({REG_ST1, 2'b01}, 8'h00, "unaligned read");
    for (int c = 0; c < 5; c++) begin
      wr(lim_idx(c), LO);
      wr(lim_idx(c) + 8'h01, HI);
    end
    // Boundary readings first, then random ones
    for (int i = 0; i < 40; i++) begin
      ch = i % 5;
      case (i / 5)
        0: r = LO;
        1: r = LO + 8'h01;
        2: r = HI;
        3: r = HI + 8'h01;
        default: r = 8'($random(seed));
      endcase
      e = viol(ch, r) ? st1_bit(ch) : 8'h00;
      @(posedge clk);
      rdg[ch] <= r;
      settle();
      rchk({REG_ST1, 2'b00}, e, "primary set");
      rchk({REG_ST1, 2'b00}, e, "primary held");
      @(posedge clk);
      rdg[ch] <= MID;
      settle();
      rchk({REG_ST1, 2'b00}, e, "primary sticky");
      rchk({REG_ST1, 2'b00}, 8'h00, "primary clear");
    end
    wr(REG_IRQ_ST, 8'hFF);
    rchk({REG_IRQ_ST, 2'b00}, 8'h00, "irq status clear");
    @(posedge clk);
    diode <= 2'b01;
    settle();
    rchk({REG_ST1, 2'b00}, 8'h80, "summary set");
    rchk({REG_ST2, 2'b00}, 8'h40, "diode one");
    rchk({REG_IRQ_ST, 2'b00}, 8'h80, "irq event");
    chk({7'h00, irq}, 8'h00, "irq masked");
    wr(REG_IRQ_MASK, 8'h80);
    settle();
    chk({7'h00, irq}, 8'h01, "irq raised");
    wr(REG_IRQ_ST, 8'h80);
    settle();
    chk({7'h00, irq}, 8'h00, "irq cleared");
    @(posedge clk);
    diode <= 2'b10;
    settle();
    rchk({REG_ST2, 2'b00}, 8'hC0, "diode two");
    @(posedge clk);
    diode <= 2'b00;
    settle();
    rchk({REG_ST2, 2'b00}, 8'h80, "diode sticky");
    rchk({REG_ST2, 2'b00}, 8'h00, "diode clear");
    rchk({REG_ST1, 2'b00}, 8'h00, "summary clear");
    @(posedge clk);
    ovt_exceed <= 1'b1;
    ovt_cool   <= 1'b0;
    settle();
    @(posedge clk);
    ovt_exceed <= 1'b0;
    settle();
    rchk({REG_ST2, 2'b00}, 8'h02, "overheat set");
    rchk({REG_ST2, 2'b00}, 8'h02, "overheat warm");
    @(posedge clk);
    ovt_cool <= 1'b1;
    settle();
    rchk({REG_ST2, 2'b00}, 8'h02, "overheat last");
    rchk({REG_ST2, 2'b00}, 8'h00, "overheat cool");
    for (int f = 0; f < 4; f++) begin
      wr(REG_FAN_SPEED_INPUT_MIN + 8'(2 * f), 8'h00);
      wr(REG_FAN_SPEED_INPUT_MIN + 8'(2 * f + 1), 8'h10);
    end
    // Fan four shares the third drive output
    for (int f = 0; f < 4; f++) begin
      e = 8'h04 << f;
      dsel = (f == 3) ? 2 : f;
      @(posedge clk);
      fan.count[f] <= 16'h1000;
      fan.drive_on <= 3'b111;
      settle();
      rchk({REG_ST2, 2'b00}, 8'h00, "fan at limit");
      @(posedge clk);
      fan.count[f] <= 16'h1001 + 16'($random(seed) & 32'h0000_0FFF);
      fan.drive_on[dsel] <= 1'b0;
      settle();
      rchk({REG_ST2, 2'b00}, 8'h00, "fan drive off");
      @(posedge clk);
      fan.drive_on <= 3'b111;
      settle();
      rchk({REG_ST2, 2'b00}, e, "fan slow");
      @(posedge clk);
      fan.count[f] <= 16'h0800;
      settle();
      rchk({REG_ST2, 2'b00}, e, "fan sticky");
      rchk({REG_ST2, 2'b00}, 8'h00, "fan clear");
    end
    wr(REG_PIN_MODE, 8'h01);
    wr(REG_ST2, 8'hFF);
    settle();
    chk({6'h00, pin_oe, pin_out}, 8'h03, "gpio drive high");
    rchk({REG_ST2, 2'b00}, 8'h20, "gpio bit");
    wr(REG_ST2, 8'h00);
    settle();
    chk({7'h00, pin_out}, 8'h00, "gpio drive low");
    wr(REG_PIN_MODE, 8'h02);
    wr(REG_TMR_LIM, 8'h03);
    rchk({REG_ST2, 2'b00}, 8'h00, "timer start");
    chk({7'h00, pin_oe}, 8'h00, "timer pin input");
    @(posedge clk);
    pin_in_n <= 1'b0;
    repeat (8) @(posedge clk);
    pin_in_n <= 1'b1;
    settle();
    rchk({REG_ST2, 2'b00}, 8'h00, "timer short");
    @(posedge clk);
    pin_in_n <= 1'b0;
    repeat (40) @(posedge clk);
    pin_in_n <= 1'b1;
    settle();
    rchk({REG_ST2, 2'b00}, 8'h20, "timer long");
    // Count still over the limit at the first read, so the flag survives it
    rchk({REG_ST2, 2'b00}, 8'h20, "timer held");
    rchk({REG_ST2, 2'b00}, 8'h00, "timer clear");
    wr(REG_PIN_MODE, 8'h00);
    // Lock is permanent, so it comes last
    wr(REG_CFG1, 8'h01);
    settle();
    chk({6'h00, mon_en, drv_full}, 8'h02, "monitor on");
    wr(REG_CFG1, 8'h03);
    wr(REG_CFG1, 8'h00);
    settle();
    chk({6'h00, mon_en, drv_full}, 8'h01, "start after lock");
    rchk({REG_CFG1, 2'b00}, 8'h06, "config locked");
    results();
  end

endmodule : test_monitor_status_flags
